// *** verification/remote_station.sv ***
// far-side serial station: framed characters on the rx line, modem status pins
`timescale 1ns/10ps
`default_nettype none
module remote_station #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic send_frame,
  input wire logic [7:0] frame_byte,
  input wire uart_mode_pkg::modem_in_t modem_next,
  output logic rx_pin,
  output uart_mode_pkg::modem_in_t modem_pin
);
  logic [9:0] shreg;
  logic [3:0] bits_left;
  int bit_cnt;
  // start bit, eight data bits lsb first, stop bit; line idles high between frames
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shreg <= 10'h3ff;
      bits_left <= 4'h0;
      bit_cnt <= 0;
    end
    else if (bits_left == 4'h0)
    begin
      if (send_frame)
      begin
        shreg <= {1'b1, frame_byte, 1'b0};
        bits_left <= 4'ha;
        bit_cnt <= BIT_CYC - 1;
      end
    end
    else if (bit_cnt == 0)
    begin
      shreg <= {1'b1, shreg[9:1]};
      bits_left <= bits_left - 4'h1;
      bit_cnt <= BIT_CYC - 1;
    end
    else
      bit_cnt <= bit_cnt - 1;
  end
  assign rx_pin = (bits_left == 4'h0) ? 1'b1 : shreg[0];
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      modem_pin <= 4'hf;
    else
      modem_pin <= modem_next;
  end
endmodule : remote_station
`default_nettype wire

// *** verification/uart_loopback_sleep_rs485_ctl_tb.sv ***
// self-checking bench for the uart mode-control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) \
  begin miscompares++; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module uart_loopback_sleep_rs485_ctl_tb;
  localparam int IDLE = 3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] fb = 8'h00;
  logic host_write_strobe = 1'b0;
  logic host_read_strobe = 1'b0;
  logic tx_core = 1'b1;
  logic hw_flow_rts_n = 1'b1;
  logic tx_fifo_write = 1'b0;
  logic char_tick = 1'b0;
  logic rx_char_valid = 1'b0;
  logic rx_char_ninth = 1'b0;
  logic low_power_input = 1'b0;
  logic send_frame = 1'b0;
  logic [3:0] quiet = 4'hf;
  logic [7:0] reg_rdata, d, v;
  logic tx_pin, rx_pin, rx_core, rts_n_pin, dtr_n_pin, user_output_one_n, user_output_two_n;
  logic rx_push, line_irq_req, uart_clk_en, baud_clk_en, host_isolate, sleeping;
  logic tx_fifo_empty, tx_shift_empty, int_pending, rx_fifo_empty;
  uart_mode_pkg::rx_char_t rx_char_in = '0;
  uart_mode_pkg::rx_char_t rx_push_char;
  uart_mode_pkg::modem_in_t modem_pin, modem_core;
  uart_mode_pkg::modem_in_t modem_next = 4'hf;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  assign {tx_fifo_empty, tx_shift_empty, int_pending, rx_fifo_empty} = quiet ^ 4'h2;
  always #25 clk = ~clk;
  uart_loopback_sleep_rs485_ctl #(.IDLE_CHARS(IDLE)) dut (.clk, .rst, .reg_addr, .reg_wdata,
    .host_write_strobe, .host_read_strobe, .reg_rdata, .tx_core, .tx_pin, .rx_pin, .rx_core,
    .modem_pin, .modem_core, .rts_n_pin, .dtr_n_pin, .user_output_one_n, .user_output_two_n,
    .hw_flow_rts_n, .tx_fifo_write, .tx_fifo_empty, .tx_shift_empty, .int_pending,
    .rx_fifo_empty, .char_tick, .rx_char_valid, .rx_char_in, .rx_char_ninth, .rx_push,
    .rx_push_char, .line_irq_req, .low_power_input, .uart_clk_en, .baud_clk_en, .host_isolate,
    .sleeping);
  remote_station u_far (.clk, .rst, .send_frame, .frame_byte(fb), .modem_next, .rx_pin,
    .modem_pin);

  function automatic uart_mode_pkg::modem_in_t loop_modem(input logic [7:0] m);
    loop_modem = {~m[1], ~m[0], ~m[3], ~m[2]};
  endfunction : loop_modem

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    host_write_strobe <= 1'b1;
    @(posedge clk) host_write_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    host_read_strobe <= 1'b1;
    @(posedge clk) host_read_strobe <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic wslp(input logic e, input int lim);
    int i;
    i = 0;
    while (sleeping !== e && i < lim)
    begin
      @(posedge clk);
      #1 i++;
    end
  endtask : wslp

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk) char_tick <= 1'b1;
      @(posedge clk) char_tick <= 1'b0;
    end
  endtask : ticks

  task automatic fwr;
    @(posedge clk) tx_fifo_write <= 1'b1;
    @(posedge clk) tx_fifo_write <= 1'b0;
    #1;
  endtask : fwr

  task automatic chr(input logic nin, input logic pe, input logic ep, input logic epe,
    input logic eirq);
    @(posedge clk);
    v = 8'($urandom);
    rx_char_valid <= 1'b1;
    rx_char_in <= {v, pe};
    rx_char_ninth <= nin;
    @(posedge clk) rx_char_valid <= 1'b0;
    #1 `CHK("push", ep, rx_push)
    if (ep) `CHK("pushed char", {v, epe}, rx_push_char)
    `CHK("line irq", eirq, line_irq_req)
  endtask : chr

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    void'($urandom(4));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 10; a++)
    begin
      v = (a == 1) ? 8'($urandom) & 8'hef : 8'($urandom);
      if (a != 7) rd(4'(a));
      if (a != 7) `CHK("reset value", 8'h00, d)
      if (a != 7) wr(4'(a), v);
      if (a != 7) rd(4'(a));
      if (a != 7) `CHK("read back", (a > 7) ? 8'h00 : v, d)
      if (a != 7) wr(4'(a), 8'h00);
    end
    for (int m = 0; m < 32; m++)
    begin
      wr(uart_mode_pkg::OFS_MODEM_CTL, 8'(m));
      for (int t = 0; t < 2; t++)
      begin
        @(posedge clk);
        tx_core <= t[0];
        modem_next <= 4'($urandom);
        repeat (2) @(posedge clk);
        #1 `CHK("tx pin", m[4] ? 1'b1 : t[0], tx_pin)
        `CHK("rx core", m[4] ? t[0] : rx_pin, rx_core)
        `CHK("modem core", m[4] ? loop_modem(8'(m)) : modem_pin, modem_core)
        `CHK("modem outs", m[4] ? 4'hf : ~4'(m), {user_output_two_n, user_output_one_n,
          rts_n_pin, dtr_n_pin})
      end
    end
    wr(uart_mode_pkg::OFS_MODEM_CTL, 8'h00);
    wr(uart_mode_pkg::OFS_EXTRA_ONE, 8'h10);
    wr(uart_mode_pkg::OFS_ENH_FEAT, 8'h10);
    repeat (8) @(posedge clk);
    #1 `CHK("half armed", 1'b0, sleeping)
    wr(uart_mode_pkg::OFS_INT_EN, 8'h10);
    wslp(1'b1, 8);
    `CHK("asleep", 1'b1, sleeping)
    `CHK("clocks gated", 2'b00, {uart_clk_en, baud_clk_en})
    rd(uart_mode_pkg::OFS_STATUS);
    `CHK("status asleep", 8'h05, d)
    fwr();
    wslp(1'b0, 4);
    `CHK("wake on write", 1'b0, sleeping)
    wslp(1'b1, 8);
    `CHK("resleep", 1'b1, sleeping)
    modem_next <= ~modem_next;
    wslp(1'b0, 6);
    `CHK("wake on modem", 1'b0, sleeping)
    wslp(1'b1, 8);
    `CHK("resleep", 1'b1, sleeping)
    for (int k = 0; k < 4; k++)
    begin
      quiet[k] <= 1'b0;
      fwr();
      repeat (8) @(posedge clk);
      #1 `CHK("blocked", 1'b0, sleeping)
      quiet <= 4'hf;
      wslp(1'b1, 8);
      `CHK("resleep", 1'b1, sleeping)
    end
    wr(uart_mode_pkg::OFS_EXTRA_ONE, 8'h00);
    fb = 8'($urandom);
    @(posedge clk) send_frame <= 1'b1;
    @(posedge clk) send_frame <= 1'b0;
    wslp(1'b0, 8);
    `CHK("wake on start", 1'b0, sleeping)
    repeat (45) @(posedge clk);
    ticks(IDLE - 1);
    repeat (4) @(posedge clk);
    #1 `CHK("idle short", 1'b0, sleeping)
    ticks(1);
    wslp(1'b1, 8);
    `CHK("idle reached", 1'b1, sleeping)
    wr(uart_mode_pkg::OFS_INT_EN, 8'h00);
    repeat (20) @(posedge clk);
    #1 `CHK("disarmed", 3'b011, {sleeping, uart_clk_en, baud_clk_en})
    @(posedge clk) low_power_input <= 1'b1;
    @(posedge clk);
    #1 `CHK("low power", 3'b001, {uart_clk_en, baud_clk_en, host_isolate})
    wr(uart_mode_pkg::OFS_MODEM_CTL, 8'h02);
    low_power_input <= 1'b0;
    rd(uart_mode_pkg::OFS_MODEM_CTL);
    `CHK("write ignored", 8'h00, d)
    `CHK("normal", 3'b110, {uart_clk_en, baud_clk_en, host_isolate})
    wr(uart_mode_pkg::OFS_ENH_FEAT, 8'h40);
    wr(uart_mode_pkg::OFS_MODEM_CTL, 8'h02);
    hw_flow_rts_n <= 1'b1;
    @(posedge clk);
    #1 `CHK("hw flow rts", hw_flow_rts_n, rts_n_pin)
    wr(uart_mode_pkg::OFS_ENH_FEAT, 8'h00);
    for (int inv = 0; inv < 2; inv++)
    begin
      wr(uart_mode_pkg::OFS_EXTRA_TWO, inv[0] ? 8'h30 : 8'h10);
      #1 `CHK("auto rts idle", ~inv[0], rts_n_pin)
      quiet <= 4'h3;
      fwr();
      `CHK("auto rts busy", inv[0], rts_n_pin)
      quiet <= 4'hb;
      repeat (3) @(posedge clk);
      #1 `CHK("shift busy", inv[0], rts_n_pin)
      quiet <= 4'hf;
      repeat (2) @(posedge clk);
      #1 `CHK("drained", ~inv[0], rts_n_pin)
    end
    wr(uart_mode_pkg::OFS_LINE_CTL, 8'h38);
    wr(uart_mode_pkg::OFS_EXTRA_TWO, 8'h01);
    wr(uart_mode_pkg::OFS_INT_EN, 8'h04);
    for (int en = 0; en < 2; en++)
    begin
      wr(uart_mode_pkg::OFS_MODEM_CTL, en[0] ? 8'h10 : 8'h00);
      wr(uart_mode_pkg::OFS_EXTRA_CTL, en[0] ? 8'h00 : 8'h02);
      for (int k = 0; k < 4; k++)
        chr(k[0], k[1], k[0] | en[0], k[0], k[0]);
    end
    wr(uart_mode_pkg::OFS_INT_EN, 8'h00);
    chr(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    wr(uart_mode_pkg::OFS_ENH_FEAT, 8'h20);
    chr(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    wr(uart_mode_pkg::OFS_ENH_FEAT, 8'h00);
    wr(uart_mode_pkg::OFS_EXTRA_TWO, 8'h00);
    chr(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    stop_test();
  end
endmodule : uart_loopback_sleep_rs485_ctl_tb
`default_nettype wire

// *** verilog/uart_loopback_sleep_rs485_ctl.sv ***
// mode control of a single uart: loopback, sleep, low power, auto rts, multidrop
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module uart_loopback_sleep_rs485_ctl #(
  parameter int IDLE_CHARS = uart_mode_pkg::IDLE_CHARS_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [uart_mode_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [uart_mode_pkg::DATA_W-1:0] reg_wdata,
  input wire logic host_write_strobe,
  input wire logic host_read_strobe,
  output logic [uart_mode_pkg::DATA_W-1:0] reg_rdata,
  input wire logic tx_core,
  output logic tx_pin,
  input wire logic rx_pin,
  output logic rx_core,
  input wire uart_mode_pkg::modem_in_t modem_pin,
  output uart_mode_pkg::modem_in_t modem_core,
  output logic rts_n_pin,
  output logic dtr_n_pin,
  output logic user_output_one_n,
  output logic user_output_two_n,
  input wire logic hw_flow_rts_n,
  input wire logic tx_fifo_write,
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic int_pending,
  input wire logic rx_fifo_empty,
  input wire logic char_tick,
  input wire logic rx_char_valid,
  input wire uart_mode_pkg::rx_char_t rx_char_in,
  input wire logic rx_char_ninth,
  output logic rx_push,
  output uart_mode_pkg::rx_char_t rx_push_char,
  output logic line_irq_req,
  input wire logic low_power_input,
  output logic uart_clk_en,
  output logic baud_clk_en,
  output logic host_isolate,
  output logic sleeping
);

  generate
    if (IDLE_CHARS < 1 || IDLE_CHARS > 7)
    begin : g_bad_idle
      $error("IDLE_CHARS must lie in 1..7");
    end
  endgenerate

  localparam logic [uart_mode_pkg::IDLE_CNT_W-1:0] IDLE_FULL =
    uart_mode_pkg::IDLE_CNT_W'(IDLE_CHARS);

  logic [7:0] modem_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] line_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] extra_feature_ctl_one;
  logic [7:0] extra_feature_ctl_two;
  logic [7:0] extra_feature_ctl;
  logic [7:0] status_word;
  logic [7:0] next_rdata;
  uart_mode_pkg::sleep_state_t sleep_state;
  uart_mode_pkg::modem_in_t modem_prev;
  logic [uart_mode_pkg::IDLE_CNT_W-1:0] idle_cnt;
  logic rts_active;
  logic loop_on;
  logic bus_ok;
  logic sleep_armed;
  logic modem_change;
  logic rx_idle_ok;
  logic sleep_cond;
  logic wake_event;
  logic auto_rts;
  logic multidrop;
  logic rx_enabled;

  // host pins are isolated in low power, so bus cycles are ignored then
  assign bus_ok = ~low_power_input;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      modem_control_reg <= uart_mode_pkg::RST_REG;
      interrupt_enable_reg <= uart_mode_pkg::RST_REG;
      line_control_reg <= uart_mode_pkg::RST_REG;
      enhanced_feature_reg <= uart_mode_pkg::RST_REG;
      extra_feature_ctl_one <= uart_mode_pkg::RST_REG;
      extra_feature_ctl_two <= uart_mode_pkg::RST_REG;
      extra_feature_ctl <= uart_mode_pkg::RST_REG;
    end
    else if (host_write_strobe && bus_ok)
    begin
      case (reg_addr)
        uart_mode_pkg::OFS_MODEM_CTL: modem_control_reg <= reg_wdata;
        uart_mode_pkg::OFS_INT_EN: interrupt_enable_reg <= reg_wdata;
        uart_mode_pkg::OFS_LINE_CTL: line_control_reg <= reg_wdata;
        uart_mode_pkg::OFS_ENH_FEAT: enhanced_feature_reg <= reg_wdata;
        uart_mode_pkg::OFS_EXTRA_ONE: extra_feature_ctl_one <= reg_wdata;
        uart_mode_pkg::OFS_EXTRA_TWO: extra_feature_ctl_two <= reg_wdata;
        uart_mode_pkg::OFS_EXTRA_CTL: extra_feature_ctl <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    status_word = 8'h00;
    status_word[uart_mode_pkg::ST_ASLEEP] = sleeping;
    status_word[uart_mode_pkg::ST_RTS_ACTIVE] = rts_active;
    status_word[uart_mode_pkg::ST_RX_ENABLED] = rx_enabled;
    status_word[uart_mode_pkg::ST_LOW_POWER] = low_power_input;
    case (reg_addr)
      uart_mode_pkg::OFS_MODEM_CTL: next_rdata = modem_control_reg;
      uart_mode_pkg::OFS_INT_EN: next_rdata = interrupt_enable_reg;
      uart_mode_pkg::OFS_LINE_CTL: next_rdata = line_control_reg;
      uart_mode_pkg::OFS_ENH_FEAT: next_rdata = enhanced_feature_reg;
      uart_mode_pkg::OFS_EXTRA_ONE: next_rdata = extra_feature_ctl_one;
      uart_mode_pkg::OFS_EXTRA_TWO: next_rdata = extra_feature_ctl_two;
      uart_mode_pkg::OFS_EXTRA_CTL: next_rdata = extra_feature_ctl;
      uart_mode_pkg::OFS_STATUS: next_rdata = status_word;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (host_read_strobe && bus_ok)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 8'h00;
  end

  // loopback: pins held at their idle level while the core talks to itself
  assign loop_on = modem_control_reg[uart_mode_pkg::MCR_LOOP];
  assign tx_pin = loop_on ? 1'b1 : tx_core;
  assign rx_core = loop_on ? tx_core : rx_pin;

  // only the status source moves; the core's interrupt logic sees it as pins
  always_comb
  begin
    if (loop_on)
    begin
      modem_core.cts_n = ~modem_control_reg[uart_mode_pkg::MCR_RTS];
      modem_core.dsr_n = ~modem_control_reg[uart_mode_pkg::MCR_DTR];
      modem_core.cd_n = ~modem_control_reg[uart_mode_pkg::MCR_OUT2];
      modem_core.ri_n = ~modem_control_reg[uart_mode_pkg::MCR_OUT1];
    end
    else
      modem_core = modem_pin;
  end

  assign dtr_n_pin = loop_on | ~modem_control_reg[uart_mode_pkg::MCR_DTR];
  assign user_output_one_n = loop_on | ~modem_control_reg[uart_mode_pkg::MCR_OUT1];
  assign user_output_two_n = loop_on | ~modem_control_reg[uart_mode_pkg::MCR_OUT2];

  // sleep control; this logic sits on the free clock, not the gated one
  assign sleep_armed = enhanced_feature_reg[uart_mode_pkg::EFR_SLEEP]
    & interrupt_enable_reg[uart_mode_pkg::IER_SLEEP];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      modem_prev <= 4'hf;
    else
      modem_prev <= modem_core;
  end

  assign modem_change = (modem_prev != modem_core);

  // character ticks come from the baud logic, which stops asleep; count holds
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      idle_cnt <= '0;
    else if (!rx_core)
      idle_cnt <= '0;
    else if (char_tick && idle_cnt != IDLE_FULL)
      idle_cnt <= idle_cnt + uart_mode_pkg::IDLE_CNT_W'(1);
  end

  assign rx_idle_ok = (idle_cnt == IDLE_FULL)
    | extra_feature_ctl_one[uart_mode_pkg::XF1_SLEEP_ANY_RX];

  assign wake_event = ~rx_core | tx_fifo_write | modem_change;

  assign sleep_cond = sleep_armed & ~modem_change & rx_idle_ok & tx_fifo_empty
    & tx_shift_empty & ~int_pending & rx_fifo_empty & ~tx_fifo_write;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sleep_state <= uart_mode_pkg::SLP_AWAKE;
    else
    begin
      case (sleep_state)
        uart_mode_pkg::SLP_AWAKE:
          if (sleep_cond && !wake_event)
            sleep_state <= uart_mode_pkg::SLP_ASLEEP;
        uart_mode_pkg::SLP_ASLEEP:
          if (wake_event || !sleep_armed)
            sleep_state <= uart_mode_pkg::SLP_AWAKE;
        default: sleep_state <= uart_mode_pkg::SLP_AWAKE;
      endcase
    end
  end

  assign sleeping = (sleep_state == uart_mode_pkg::SLP_ASLEEP);
  // low power bypasses the state machine so it acts in the same cycle
  assign uart_clk_en = ~sleeping & ~low_power_input;
  assign baud_clk_en = ~sleeping & ~low_power_input;
  assign host_isolate = low_power_input;

  // automatic turn-around; a write in the draining cycle keeps rts asserted
  assign auto_rts = extra_feature_ctl_two[uart_mode_pkg::XF2_AUTO_RTS];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rts_active <= 1'b0;
    else if (tx_fifo_write)
      rts_active <= 1'b1;
    else if (tx_fifo_empty && tx_shift_empty)
      rts_active <= 1'b0;
  end

  always_comb
  begin
    if (loop_on)
      rts_n_pin = 1'b1;
    else if (auto_rts)
      rts_n_pin = extra_feature_ctl_two[uart_mode_pkg::XF2_RTS_INV]
        ? rts_active : ~rts_active;
    else if (enhanced_feature_reg[uart_mode_pkg::EFR_HW_RTS])
      rts_n_pin = hw_flow_rts_n;
    else
      rts_n_pin = ~modem_control_reg[uart_mode_pkg::MCR_RTS];
  end

  // multidrop without special-character matching
  assign multidrop = extra_feature_ctl_two[uart_mode_pkg::XF2_MULTIDROP]
    & ~enhanced_feature_reg[uart_mode_pkg::EFR_SPECIAL];
  assign rx_enabled = ~extra_feature_ctl[uart_mode_pkg::XFC_RX_DISABLE];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_push <= 1'b0;
      rx_push_char <= '0;
      line_irq_req <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      line_irq_req <= 1'b0;
      if (rx_char_valid)
      begin
        rx_push_char.data <= rx_char_in.data;
        if (!multidrop)
        begin
          rx_push <= 1'b1;
          rx_push_char.perr <= rx_char_in.perr;
        end
        else if (rx_char_ninth)
        begin
          rx_push <= 1'b1;
          rx_push_char.perr <= 1'b1;
          line_irq_req <= interrupt_enable_reg[uart_mode_pkg::IER_LSI];
        end
        else
        begin
          rx_push <= rx_enabled;
          rx_push_char.perr <= 1'b0;
        end
      end
    end
  end

  sequence s_wake;
    sleeping && wake_event;
  endsequence

  sequence s_awake_quiet;
    !sleeping && sleep_cond && !wake_event;
  endsequence

  AST_LOOP_RX: assert property (@(posedge clk) disable iff (rst)
    loop_on |-> (rx_core == tx_core) && tx_pin)
    else $error("loopback did not join tx to rx");

  AST_LOOP_MODEM: assert property (@(posedge clk) disable iff (rst)
    loop_on |-> modem_core.cts_n == ~modem_control_reg[uart_mode_pkg::MCR_RTS]
      && modem_core.cd_n == ~modem_control_reg[uart_mode_pkg::MCR_OUT2])
    else $error("looped modem status wrong");

  AST_NORMAL_MODEM: assert property (@(posedge clk) disable iff (rst)
    !loop_on |-> modem_core == modem_pin)
    else $error("modem pins not passed through");

  AST_SLEEP_NEEDS_ARM: assert property (@(posedge clk) disable iff (rst)
    $rose(sleeping) |-> $past(sleep_armed) && $past(tx_shift_empty)
      && $past(rx_fifo_empty) && !$past(int_pending))
    else $error("entered sleep without conditions");

  AST_ENTER: assert property (@(posedge clk) disable iff (rst)
    s_awake_quiet |=> sleeping)
    else $error("did not re-enter sleep");

  AST_WAKE: assert property (@(posedge clk) disable iff (rst)
    s_wake |=> !sleeping ##0 uart_clk_en || low_power_input)
    else $error("did not wake on event");

  AST_DISARM: assert property (@(posedge clk) disable iff (rst)
    !sleep_armed |=> !sleeping)
    else $error("sleep held after disarm");

  AST_CLK_GATE: assert property (@(posedge clk) disable iff (rst)
    sleeping |-> !uart_clk_en && !baud_clk_en)
    else $error("clocks run while asleep");

  AST_LOW_POWER: assert property (@(posedge clk) disable iff (rst)
    low_power_input |-> (!uart_clk_en && !baud_clk_en && host_isolate) ##1 reg_rdata == 8'h00)
    else $error("low power did not stop clocks");

  AST_RTS_AUTO: assert property (@(posedge clk) disable iff (rst)
    (auto_rts && !loop_on && tx_fifo_write) ##1 (auto_rts && !loop_on)
      |-> rts_n_pin == extra_feature_ctl_two[uart_mode_pkg::XF2_RTS_INV])
    else $error("auto rts not asserted after write");

  AST_ADDR_FLAG: assert property (@(posedge clk) disable iff (rst)
    (rx_char_valid && multidrop && rx_char_ninth) |=> rx_push && rx_push_char.perr)
    else $error("address char not stored with error");

  AST_DATA_DROP: assert property (@(posedge clk) disable iff (rst)
    (rx_char_valid && multidrop && !rx_char_ninth && !rx_enabled) |=> !rx_push)
    else $error("data kept while receiver disabled");

endmodule : uart_loopback_sleep_rs485_ctl
`default_nettype wire

// *** verilog/uart_mode_pkg.sv ***
// constants, register map and carrier types for the uart mode-control block
`default_nettype none
package uart_mode_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] OFS_MODEM_CTL = 4'h0;
  localparam logic [3:0] OFS_INT_EN = 4'h1;
  localparam logic [3:0] OFS_LINE_CTL = 4'h2;
  localparam logic [3:0] OFS_ENH_FEAT = 4'h3;
  localparam logic [3:0] OFS_EXTRA_ONE = 4'h4;
  localparam logic [3:0] OFS_EXTRA_TWO = 4'h5;
  localparam logic [3:0] OFS_EXTRA_CTL = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;

  localparam logic [7:0] RST_REG = 8'h00;

  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int IER_LSI = 2;
  localparam int IER_SLEEP = 4;
  localparam int EFR_SLEEP = 4;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_HW_RTS = 6;
  localparam int XF1_SLEEP_ANY_RX = 4;
  localparam int XF2_MULTIDROP = 0;
  localparam int XF2_AUTO_RTS = 4;
  localparam int XF2_RTS_INV = 5;
  localparam int XFC_RX_DISABLE = 1;

  localparam int ST_ASLEEP = 0;
  localparam int ST_RTS_ACTIVE = 1;
  localparam int ST_RX_ENABLED = 2;
  localparam int ST_LOW_POWER = 3;

  localparam int IDLE_CHARS_DEF = 4;
  localparam int IDLE_CNT_W = 3;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } modem_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic perr;
  } rx_char_t;

  typedef enum logic [0:0] {
    SLP_AWAKE = 1'b0,
    SLP_ASLEEP = 1'b1
  } sleep_state_t;

endpackage : uart_mode_pkg
`default_nettype wire
